// [src/udma_pkg.sv]
package udma_pkg;

  // internal clock period, picoseconds
  localparam int CLK_PERIOD_PS = 40000;

  // number of selectable transfer modes and counter width
  localparam int MODE_COUNT = 7;
  localparam int CNT_W      = 8;

  // sender data valid setup before a strobe edge, per mode, picoseconds
  localparam int T_DVS_PS [0:6] = '{72900, 50900, 33900, 22600, 9500, 6000, 5200};
  // sender data valid hold after a strobe edge, per mode, picoseconds
  localparam int T_DVH_PS [0:6] = '{9000, 9000, 9000, 9000, 9000, 6000, 5200};
  // least spacing of strobe edges, per mode, picoseconds
  localparam int T_CYC_PS [0:6] = '{120000, 120000, 120000, 120000, 120000, 120000, 120000};
  // least delay from acknowledge to driving the strobe line, picoseconds
  localparam int T_ZIORDY_PS = 20000;
  // least delay from host ready to driving the data bus, picoseconds
  localparam int T_ZAD_PS    = 20000;

  // reset values of the link outputs
  localparam logic       DMARQ_RST  = 1'b0;
  localparam logic       STROBE_RST = 1'b1;
  localparam logic [15:0] DATA_RST  = 16'h0000;

  // least time to whole clock cycles, rounded up, never below one
  function automatic logic [CNT_W-1:0] cyc_min(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    if (c < 1)
    begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction : cyc_min

endpackage : udma_pkg

// [src/word_fifo_if.sv]
`timescale 1ns/1ns
interface word_fifo_if #(parameter int WIDTH = 16);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport fill  (output wr_valid, wr_data, input wr_ready);
  modport drain (input rd_valid, rd_data, output rd_ready);
endinterface : word_fifo_if

// [src/word_fifo.sv]
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  logic         clk_sys,
  input  logic         rst_b,
  // both sides of the buffer
  word_fifo_if.store   port
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [0:DEPTH-1];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             full;
  logic             empty;

  // extra pointer bit tells full from empty
  assign empty        = (wr_ptr_q == rd_ptr_q);
  assign full         = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
  assign port.wr_ready = !full;
  assign port.rd_valid = !empty;
  assign port.rd_data  = mem_q[rd_ptr_q[AW-1:0]];

  // storage write
  always_ff @(posedge clk_sys)
  begin
    if (port.wr_valid && !full)
    begin
      mem_q[wr_ptr_q[AW-1:0]] <= port.wr_data;
    end
  end

  // pointers
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (port.wr_valid && !full)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (port.rd_ready && !empty)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : word_fifo

// [src/udma_data_in_burst.sv]
`timescale 1ns/1ns
// Notes on behaviour
// - request held until first strobe negation
// - strobe driven after delay, kept until release
// - data driven only after host ready delay
// - first word placed when bus first driven
// - first strobe negation after data setup
// - lines meaningful only while request and acknowledge
// - each edge follows data setup; both edges
// - edges spaced by cycle time per mode
// - data held after edge, then repeat
// - edges stop quickly when ready negated
// - device pause withholds edges after first word
module udma_data_in_burst #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input  logic        clk_sys,
  input  logic        rst_b,
  // user side word stream
  input  logic        in_valid,
  output logic        in_ready,
  input  logic [15:0] in_data,
  // user side control and status
  input  logic        burst_en,
  input  logic        pause_req,
  input  logic [2:0]  udma_mode,
  output logic        burst_active,
  // link pins from the host
  input  logic        dmack_b,
  input  logic        stop,
  input  logic        hdmardy_b,
  // link pins to the host, and the data bus input
  output logic        dmarq,
  output logic        dstrobe_out,
  output logic        dstrobe_oe,
  input  logic [15:0] dd_in,
  output logic [15:0] dd_out,
  output logic        dd_oe
);

  typedef enum logic [2:0] {
    IDLE        = 3'h0,
    REQUEST     = 3'h1,
    WAIT_ENV    = 3'h2,
    FIRST_DRIVE = 3'h3,
    RUN         = 3'h4,
    ENDING      = 3'h5
  } state_type;

  localparam int CW = udma_pkg::CNT_W;

  state_type          state_q;
  logic [2:0]         mode_q;
  logic [2:0]         pin_meta_q;
  logic [2:0]         pin_sync_q;
  logic               ack_on;
  logic               stop_on;
  logic               ready_on;
  logic               link_on;
  logic [CW-1:0]      gap_cnt_q;
  logic [CW-1:0]      dv_cnt_q;
  logic [CW-1:0]      edge_cnt_q;
  logic               loaded_q;
  logic               moved_q;
  logic               dmarq_q;
  logic               strobe_q;
  logic               strobe_oe_q;
  logic [15:0]        word_q;
  logic               dd_oe_q;
  logic [CW-1:0]      n_dvs;
  logic [CW-1:0]      n_dvh;
  logic [CW-1:0]      n_cyc;
  logic [CW-1:0]      n_ziordy;
  logic [CW-1:0]      n_zad;
  logic               load_word;
  logic               fire_edge;
  logic               take_first;

  word_fifo_if #(.WIDTH(16)) fifo ();

  // saturating count step
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    return (v == {CW{1'b1}}) ? v : v + 1'b1;
  endfunction : sat_inc

  ////////////////////////////////////////////////////////////////////////////////
  // buffer in the data path

  word_fifo #(
    .WIDTH (16),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .port    (fifo.store)
  );

  assign fifo.wr_valid = in_valid;
  assign fifo.wr_data  = in_data;
  assign in_ready      = fifo.wr_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops each

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_meta_q <= 3'h5;
      pin_sync_q <= 3'h5;
    end
    else
    begin
      pin_meta_q <= {hdmardy_b, stop, dmack_b};
      pin_sync_q <= pin_meta_q;
    end
  end

  // handshake lines take burst meaning only while both ends agree
  assign ack_on   = !pin_sync_q[0];
  assign link_on  = dmarq_q && ack_on;
  assign stop_on  = link_on && pin_sync_q[1];
  assign ready_on = link_on && !pin_sync_q[2];

  ////////////////////////////////////////////////////////////////////////////////
  // cycle counts, per mode for setup, hold and spacing

  always_comb
  begin
    n_dvs    = udma_pkg::cyc_min(udma_pkg::T_DVS_PS[mode_q]);
    n_dvh    = udma_pkg::cyc_min(udma_pkg::T_DVH_PS[mode_q]);
    n_cyc    = udma_pkg::cyc_min(udma_pkg::T_CYC_PS[mode_q]);
    n_ziordy = udma_pkg::cyc_min(udma_pkg::T_ZIORDY_PS);
    n_zad    = udma_pkg::cyc_min(udma_pkg::T_ZAD_PS);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // word and edge decisions

  // first word goes out once the bus may be driven
  assign take_first = (state_q == FIRST_DRIVE) && (gap_cnt_q >= n_zad) && fifo.rd_valid;
  // next word replaces the strobed one after the hold time
  assign load_word  = (state_q == RUN) && !loaded_q && (edge_cnt_q >= n_dvh)
                      && fifo.rd_valid && !stop_on;
  assign fifo.rd_ready = take_first || load_word;
  // edge after setup and spacing, withheld on host or device pause
  assign fire_edge  = (state_q == RUN) && loaded_q && ready_on && !stop_on
                      && (dv_cnt_q >= n_dvs)
                      && (edge_cnt_q >= n_cyc)
                      && !(pause_req && moved_q);

  ////////////////////////////////////////////////////////////////////////////////
  // burst sequence

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= IDLE;
      mode_q  <= 3'h0;
    end
    else
    begin
      case (state_q)
        IDLE:
        begin
          if (burst_en && fifo.rd_valid)
          begin
            state_q <= REQUEST;
            mode_q  <= (udma_mode > 3'h6) ? 3'h6 : udma_mode;
          end
        end
        REQUEST:
        begin
          if (ack_on)
          begin
            state_q <= WAIT_ENV;
          end
        end
        WAIT_ENV:
        begin
          if (!ack_on)
          begin
            state_q <= IDLE;
          end
          else if (strobe_oe_q && ready_on && !stop_on)
          begin
            state_q <= FIRST_DRIVE;
          end
        end
        FIRST_DRIVE:
        begin
          if (!ack_on)
          begin
            state_q <= IDLE;
          end
          else if (take_first)
          begin
            state_q <= RUN;
          end
        end
        RUN:
        begin
          if (!ack_on)
          begin
            state_q <= IDLE;
          end
          else if (stop_on && moved_q)
          begin
            state_q <= ENDING;
          end
        end
        ENDING:
        begin
          if (!ack_on)
          begin
            state_q <= IDLE;
          end
        end
        default:
        begin
          state_q <= IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interval counters

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap_cnt_q  <= '0;
      dv_cnt_q   <= '0;
      edge_cnt_q <= '0;
    end
    else
    begin
      // time since acknowledge, then since host ready
      if ((state_q == REQUEST) || ((state_q == WAIT_ENV) && (state_q != FIRST_DRIVE)
          && ready_on && strobe_oe_q && !stop_on))
      begin
        gap_cnt_q <= '0;
      end
      else
      begin
        gap_cnt_q <= sat_inc(gap_cnt_q);
      end
      dv_cnt_q   <= (take_first || load_word) ? '0 : sat_inc(dv_cnt_q);
      edge_cnt_q <= take_first ? {CW{1'b1}} : (fire_edge ? '0 : sat_inc(edge_cnt_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request line

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dmarq_q <= udma_pkg::DMARQ_RST;
    end
    else if ((state_q == IDLE) && burst_en && fifo.rd_valid)
    begin
      dmarq_q <= 1'b1;
    end
    else if ((state_q == ENDING) || !burst_active)
    begin
      dmarq_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strobe line

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strobe_q    <= udma_pkg::STROBE_RST;
      strobe_oe_q <= 1'b0;
      moved_q     <= 1'b0;
    end
    else if (!burst_active || ((state_q != REQUEST) && !ack_on))
    begin
      strobe_q    <= udma_pkg::STROBE_RST;
      strobe_oe_q <= 1'b0;
      moved_q     <= 1'b0;
    end
    else
    begin
      if ((state_q == WAIT_ENV) && (gap_cnt_q >= n_ziordy))
      begin
        strobe_oe_q <= 1'b1;
      end
      if (fire_edge)
      begin
        strobe_q <= !strobe_q;
        moved_q  <= 1'b1;
      end
      else if (state_q == ENDING)
      begin
        strobe_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data bus

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_q   <= udma_pkg::DATA_RST;
      dd_oe_q  <= 1'b0;
      loaded_q <= 1'b0;
    end
    else
    begin
      if (take_first || load_word)
      begin
        word_q   <= fifo.rd_data;
        loaded_q <= 1'b1;
      end
      else if (fire_edge)
      begin
        loaded_q <= 1'b0;
      end
      if (take_first)
      begin
        dd_oe_q <= 1'b1;
      end
      else if ((state_q != RUN) || !ack_on || stop_on)
      begin
        dd_oe_q  <= 1'b0;
        loaded_q <= 1'b0;
      end
    end
  end

  assign burst_active = (state_q != IDLE);
  assign dmarq        = dmarq_q;
  assign dstrobe_out  = strobe_q;
  assign dstrobe_oe   = strobe_oe_q;
  assign dd_out       = word_q;
  assign dd_oe        = dd_oe_q;

endmodule : udma_data_in_burst

// [verif/udma_asserts.sv]
`timescale 1ns/1ns
module udma_asserts (
  // clock and reset
  input logic        clk_sys,
  input logic        rst_b,
  // user side
  input logic        in_ready,
  input logic        pause_req,
  // link pins
  input logic        dmack_b,
  input logic        stop,
  input logic        hdmardy_b,
  input logic        dmarq,
  input logic        dstrobe_out,
  input logic        dstrobe_oe,
  input logic [15:0] dd_out,
  input logic        dd_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic seen_q;

  // first strobe negation seen in this burst
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b) seen_q <= 1'b0;
    else if (!dmarq) seen_q <= 1'b0;
    else if (dstrobe_oe && !dstrobe_out) seen_q <= 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  AST_REQ_HELD: assert property ($fell(dmarq) |-> seen_q)
    else $error("request dropped before first strobe negation");
  AST_STB_DRIVE: assert property ($rose(dstrobe_oe) |-> $past(dmack_b, 2) == 1'b0)
    else $error("strobe driven before acknowledge");
  AST_STB_KEEP: assert property (dstrobe_oe && !dmack_b |=> dstrobe_oe)
    else $error("strobe released while acknowledged");
  AST_DATA_DRIVE: assert property ($rose(dd_oe) |->
      $past(stop, 2) == 1'b0 && $past(hdmardy_b, 2) == 1'b0 && $past(dmack_b, 2) == 1'b0)
    else $error("data driven before host ready");
  AST_FIRST_WORD: assert property ($rose(dd_oe) |-> dstrobe_out && dstrobe_oe)
    else $error("first word not on bus before strobe");
  AST_SETUP: assert property (dmarq && $changed(dstrobe_out) |-> $past(dd_oe) && $stable(dd_out))
    else $error("strobe edge without data setup");
  AST_HOLD: assert property (dmarq && $changed(dstrobe_out) |=> $stable(dd_out))
    else $error("data changed within hold");
  AST_SPACING: assert property (dmarq && $changed(dstrobe_out) |=>
      (!$changed(dstrobe_out) || !dmarq)[*2])
    else $error("strobe edges too close");
  AST_HOST_PAUSE: assert property (hdmardy_b[*4] |-> !$changed(dstrobe_out) || !dmarq)
    else $error("strobe edge while host paused");
  AST_DEV_PAUSE: assert property ((pause_req && seen_q)[*3] |-> !$changed(dstrobe_out))
    else $error("strobe edge while device paused");

  // main scenarios
  cover property (dmarq && $fell(dstrobe_out));
  cover property (!in_ready);
  cover property (dmarq && seen_q && hdmardy_b);
  cover property (pause_req && seen_q);
endmodule : udma_asserts

bind udma_data_in_burst udma_asserts i_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .in_ready(in_ready), .pause_req(pause_req),
  .dmack_b(dmack_b), .stop(stop), .hdmardy_b(hdmardy_b), .dmarq(dmarq),
  .dstrobe_out(dstrobe_out), .dstrobe_oe(dstrobe_oe), .dd_out(dd_out), .dd_oe(dd_oe)
);

// [verif/host_model.sv]
`timescale 1ns/1ns
module host_model (
  // host clock and reset
  input  logic lclk,
  input  logic rst_b,
  // device request and bench commands
  input  logic dmarq,
  input  logic hold,
  input  logic quit,
  // handshake pins
  output logic dmack_b,
  output logic stop,
  output logic hdmardy_b
);
  // handshake steps, one per rising host clock edge
  always @(posedge lclk or negedge rst_b)
    if (!rst_b)
    begin
      dmack_b   <= 1'b1;
      stop      <= 1'b1;
      hdmardy_b <= 1'b1;
    end
    else if (quit)
    begin
      hdmardy_b <= 1'b1;
      if (hdmardy_b) stop <= 1'b1;
      if (!dmarq && stop) dmack_b <= 1'b1;
    end
    // idle: stop held asserted and host ready negated, acknowledge asserted on request
    else if (dmack_b)
    begin
      stop      <= 1'b1;
      hdmardy_b <= 1'b1;
      if (dmarq) dmack_b <= 1'b0;
    end
    else if (stop)
    begin
      stop      <= 1'b0;
      hdmardy_b <= 1'b0;
    end
    else hdmardy_b <= hold;
endmodule : host_model

// [verif/tb.sv]
`timescale 1ns/1ns
module tb;
  logic        clk_sys   = 1'b0;
  logic        lclk      = 1'b0;
  logic        rst_b     = 1'b0;
  logic        in_valid  = 1'b0;
  logic [15:0] in_data   = 16'h0000;
  logic        burst_en  = 1'b0;
  logic        pause_req = 1'b0;
  logic [2:0]  udma_mode = 3'h0;
  logic        hold      = 1'b0;
  logic        quit      = 1'b0;
  logic        strb_q    = 1'b1;
  logic        oe_q      = 1'b0;
  logic [15:0] dd_q      = 16'h0000;
  time         t_word    = 0;
  time         t_edge    = 0;
  time         el_ps     = 0;
  int          md        = 0;
  logic        in_ready, burst_active, dmack_b, stop, hdmardy_b;
  logic        dmarq, dstrobe_out, dstrobe_oe, dd_oe;
  logic [15:0] dd_in, dd_out;
  logic [15:0] got [$];
  int          errors  = 0;
  int          checked = 0;

  always #20 clk_sys = ~clk_sys;
  initial #7 forever #160 lclk = ~lclk;
  // released bus shows the inverse of the last word
  assign dd_in = dd_oe ? dd_out : ~dd_out;

  udma_data_in_burst #(.DEPTH(16)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .in_valid(in_valid), .in_ready(in_ready),
    .in_data(in_data), .burst_en(burst_en), .pause_req(pause_req),
    .udma_mode(udma_mode), .burst_active(burst_active), .dmack_b(dmack_b),
    .stop(stop), .hdmardy_b(hdmardy_b), .dmarq(dmarq), .dstrobe_out(dstrobe_out),
    .dstrobe_oe(dstrobe_oe), .dd_in(dd_in), .dd_out(dd_out), .dd_oe(dd_oe)
  );
  host_model i_host (
    .lclk(lclk), .rst_b(rst_b), .dmarq(dmarq), .hold(hold), .quit(quit),
    .dmack_b(dmack_b), .stop(stop), .hdmardy_b(hdmardy_b)
  );

  // one word per strobe edge, first edge falling; setup, spacing and hold timed per mode
  always @(negedge clk_sys)
  begin
    md = (udma_mode > 3'h6) ? 6 : int'(udma_mode);
    if (dd_oe && (!oe_q || dd_out !== dd_q))
    begin
      el_ps = ($time - t_edge) * 1000;
      if (oe_q) chk({15'h0000, el_ps >= udma_pkg::T_DVH_PS[md]}, 16'h0001);
      t_word = $time;
    end
    if (dstrobe_oe && dmarq && !dmack_b && dstrobe_out !== strb_q)
    begin
      el_ps = ($time - t_edge) * 1000;
      if (got.size() == 0) chk({15'h0000, dstrobe_out}, 16'h0000);
      else chk({15'h0000, el_ps >= udma_pkg::T_CYC_PS[md]}, 16'h0001);
      el_ps = ($time - t_word) * 1000;
      chk({15'h0000, el_ps >= udma_pkg::T_DVS_PS[md]}, 16'h0001);
      got.push_back(dd_out);
      t_edge = $time;
    end
    strb_q = dstrobe_out;
    oe_q   = dd_oe;
    dd_q   = dd_out;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic push_n(input logic [15:0] base, input int n);
    int k;
    in_valid <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      in_data <= base + 16'(i);
      k = 0;
      @(negedge clk_sys);
      while (!in_ready && k < 3000)
      begin
        @(negedge clk_sys);
        k++;
      end
      chk({15'h0000, in_ready}, 16'h0001);
      @(posedge clk_sys);
    end
    in_valid <= 1'b0;
  endtask : push_n

  task automatic wait_n(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
  endtask : wait_n

  task automatic check_all(input logic [15:0] base, input int n);
    chk(16'(got.size()), 16'(n));
    for (int i = 0; i < n; i++) chk(got[i], base + 16'(i));
    got.delete();
  endtask : check_all

  task automatic end_burst;
    int k;
    k = 0;
    quit     <= 1'b1;
    burst_en <= 1'b0;
    @(negedge clk_sys);
    while (burst_active && k < 3000)
    begin
      @(negedge clk_sys);
      k++;
    end
    chk({13'h0000, burst_active, dmarq, dstrobe_oe}, 16'h0000);
    @(posedge clk_sys);
    quit <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask : end_burst

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge clk_sys);
    chk({11'h000, dmarq, dstrobe_oe, dd_oe, burst_active, in_ready}, 16'h0001);
    @(posedge clk_sys);
    $display("test reset done");
  endtask : t_reset

  task automatic t_modes;
    for (int m = 0; m < 8; m++)
    begin
      udma_mode <= 3'(m);
      push_n({1'b0, 3'(m), 12'h5a0}, 5);
      burst_en <= 1'b1;
      wait_n(5);
      check_all({1'b0, 3'(m), 12'h5a0}, 5);
      end_burst();
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_fill;
    int n;
    push_n(16'hc000, 16);
    @(negedge clk_sys);
    chk({15'h0000, in_ready}, 16'h0000);
    @(posedge clk_sys);
    burst_en <= 1'b1;
    wait_n(3);
    hold <= 1'b1;
    repeat (40) @(posedge clk_sys);
    n = got.size();
    repeat (40) @(posedge clk_sys);
    chk(16'(got.size()), 16'(n));
    hold <= 1'b0;
    wait_n(16);
    check_all(16'hc000, 16);
    end_burst();
    $display("test fill and host pause done");
  endtask : t_fill

  task automatic t_dpause;
    int n;
    push_n(16'h7100, 6);
    burst_en <= 1'b1;
    wait_n(1);
    pause_req <= 1'b1;
    repeat (40) @(posedge clk_sys);
    n = got.size();
    repeat (40) @(negedge clk_sys);
    chk(16'(got.size()), 16'(n));
    chk({15'h0000, dmarq}, 16'h0001);
    @(posedge clk_sys);
    pause_req <= 1'b0;
    wait_n(6);
    check_all(16'h7100, 6);
    end_burst();
    $display("test device pause done");
  endtask : t_dpause

  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // watchdog
  initial
  begin
    #2000000;
    errors++;
    final_report();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_modes();
    t_fill();
    t_dpause();
    final_report();
  end
endmodule : tb
